/* File: src/sps_pkg.sv */
package sps_pkg;
  localparam int PAGE_W = 3;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CURRENT_PAGE = 8'hD0;
  localparam logic [7:0] IDX_STACK_PAGE   = 8'hD1;
  localparam logic [7:0] IDX_INDEX_PAGE   = 8'hD3;
  localparam logic [7:0] IDX_MOVE_READ    = 8'hD4;
  localparam logic [7:0] IDX_MOVE_WRITE   = 8'hD5;
  localparam logic [7:0] IDX_SCRATCH_BASE = 8'h60;
  localparam logic [7:0] IDX_STATUS       = 8'h70;
  localparam int         SCRATCH_IDX_LSB  = 2;
  // Reset values
  localparam logic [PAGE_W-1:0] RST_PAGE    = 3'h0;
  localparam logic [DATA_W-1:0] RST_SCRATCH = 8'h00;
  // Page mode encodings
  localparam logic [1:0] MODE_ALL_ZERO  = 2'h0;
  localparam logic [1:0] MODE_IDX_STACK = 2'h1;
  localparam logic [1:0] MODE_IDX_PAGE  = 2'h2;
  localparam logic [1:0] MODE_CUR_STACK = 2'h3;
  localparam int         MODE_CUR_BIT   = 1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status register field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_STEP_LSB = 2;
  localparam int STAT_BUSY_BIT = 4;

  typedef enum logic [2:0] {
    ACC_NORMAL  = 3'h0,
    ACC_STACK   = 3'h1,
    ACC_SRC_IDX = 3'h2,
    ACC_DST_IDX = 3'h3,
    ACC_MVI_RD  = 3'h4,
    ACC_MVI_WR  = 3'h5
  } sps_acc_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_PTR_RD = 2'h1,
    ST_PTR_WR = 2'h3,
    ST_DATA   = 2'h2
  } sps_step_t;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'h0,
    SEL_CUR   = 3'h1,
    SEL_STK   = 3'h2,
    SEL_IDX   = 3'h3,
    SEL_MVR   = 3'h4,
    SEL_MVW   = 3'h5,
    SEL_SCR   = 3'h6,
    SEL_STAT  = 3'h7
  } sps_sel_t;

  typedef struct packed {
    logic [PAGE_W-1:0] cur;
    logic [PAGE_W-1:0] stk;
    logic [PAGE_W-1:0] idx;
    logic [PAGE_W-1:0] mvr;
    logic [PAGE_W-1:0] mvw;
  } sps_ptrs_t;

  typedef struct packed {
    logic     valid;
    sps_acc_t kind;
    logic     we;
    logic [1:0] page_mode_bits;
  } sps_req_t;
endpackage

/* File: src/sps_page_sel.sv */
`timescale 1ns/1ps
module sps_page_sel (
  // Pointers and access
  input  sps_pkg::sps_ptrs_t           ptrs,
  input  wire logic [1:0]              page_mode_bits,
  input  sps_pkg::sps_acc_t            kind,
  input  wire logic                    data_phase,
  // Selected page
  output logic [sps_pkg::PAGE_W-1:0]   page
);
  logic [sps_pkg::PAGE_W-1:0] normal_page;

  always_comb begin
    normal_page = page_mode_bits[sps_pkg::MODE_CUR_BIT] ? ptrs.cur : sps_pkg::RST_PAGE;
    page        = normal_page;
    unique case (kind)
      sps_pkg::ACC_NORMAL: page = normal_page;
      sps_pkg::ACC_STACK:  page = ptrs.stk;
      sps_pkg::ACC_SRC_IDX, sps_pkg::ACC_DST_IDX: begin
        unique case (page_mode_bits)
          sps_pkg::MODE_ALL_ZERO:  page = sps_pkg::RST_PAGE;
          sps_pkg::MODE_IDX_STACK: page = ptrs.stk;
          sps_pkg::MODE_IDX_PAGE:  page = ptrs.idx;
          sps_pkg::MODE_CUR_STACK: page = ptrs.stk;
        endcase
      end
      // Pointer byte sits in the normal page, data in the move page
      sps_pkg::ACC_MVI_RD: page = data_phase ? ptrs.mvr : normal_page;
      sps_pkg::ACC_MVI_WR: page = data_phase ? ptrs.mvw : normal_page;
      default:             page = normal_page;
    endcase
  end
endmodule // sps_page_sel

/* File: src/sps_axil_slave.sv */
`timescale 1ns/1ps
module sps_axil_slave #(
  parameter int ADDR_W = sps_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Register file side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);
  logic aw_held_q;
  logic w_held_q;

  assign wr_en   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_en   = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        wr_addr   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wr_data  <= s_axi_wdata;
        wr_strb  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sps_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? sps_pkg::RESP_SLVERR : sps_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sps_pkg::RESP_OKAY;
    end else if (rd_en) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? sps_pkg::RESP_SLVERR : sps_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule // sps_axil_slave

/* File: src/sps_page_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - Four 8-bit scratch registers, plain storage
// - Scratch and status reachable in any bank, others bank zero
// - Normal accesses use current page in modes 10b/11b
// - Current page never steers stack or indexed
// - Move pointer byte lives in the normal page
// - Stack page pointer resets to zero
// - Next push or pop uses newly written page
// - Stack always uses stack page pointer
// - Mode 11b sends indexed accesses to stack page
// - Index page pointer acts only in mode 10b
// - Move read data uses move-read page
// - Move write data uses move-write page
// - Move pointers ignore the page mode bits
// - Mode 00b forces page zero except for stack and move data; 01b indexed stack
// - Move does pointer read, pointer write, data
module sps_page_ctrl #(
  parameter int NUM_SCRATCH = 4,
  parameter int ADDR_W      = sps_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Core side
  input  wire logic                        reg_bank_sel,
  input  sps_pkg::sps_req_t                core_req,
  output logic                             core_busy_q,
  // SRAM page beat
  output logic                             sram_valid_q,
  output logic [sps_pkg::PAGE_W-1:0]       sram_page_q,
  output logic                             sram_we_q,
  output sps_pkg::sps_acc_t                sram_kind_q,
  output sps_pkg::sps_step_t               mvi_step_q
);
  sps_pkg::sps_ptrs_t ptrs_q;
  sps_pkg::sps_ptrs_t ptrs_d;
  logic [sps_pkg::DATA_W-1:0] scratch_q [NUM_SCRATCH];
  logic [sps_pkg::DATA_W-1:0] scratch_d [NUM_SCRATCH];
  logic [1:0]                 mode_q;
  sps_pkg::sps_step_t         step_d;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              wr_err;
  logic              rd_err;
  sps_pkg::sps_sel_t wr_sel;
  sps_pkg::sps_sel_t rd_sel;
  logic [1:0]        wr_scr;
  logic [1:0]        rd_scr;
  logic              wr_lane0;

  logic              accept;
  logic              beat;
  sps_pkg::sps_acc_t sel_kind;
  logic [1:0]        sel_mode;
  logic              sel_we;
  logic              sel_data;
  logic [sps_pkg::PAGE_W-1:0] sel_page;

  localparam int SCRATCH_IDX_W = sps_pkg::SCRATCH_IDX_LSB;

  // Word decode; paging pointers vanish outside bank zero
  function automatic sps_pkg::sps_sel_t reg_decode(input logic [ADDR_W-1:0] addr, input logic bank);
    logic [7:0] idx;
    idx = addr[9:2];
    reg_decode = sps_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0 && addr[ADDR_W-1:10] == '0) begin
      if (idx[7:SCRATCH_IDX_W] == sps_pkg::IDX_SCRATCH_BASE[7:SCRATCH_IDX_W])
        reg_decode = sps_pkg::SEL_SCR;
      else if (idx == sps_pkg::IDX_STATUS)
        reg_decode = sps_pkg::SEL_STAT;
      else if (!bank) begin
        unique case (idx)
          sps_pkg::IDX_CURRENT_PAGE: reg_decode = sps_pkg::SEL_CUR;
          sps_pkg::IDX_STACK_PAGE:   reg_decode = sps_pkg::SEL_STK;
          sps_pkg::IDX_INDEX_PAGE:   reg_decode = sps_pkg::SEL_IDX;
          sps_pkg::IDX_MOVE_READ:    reg_decode = sps_pkg::SEL_MVR;
          sps_pkg::IDX_MOVE_WRITE:   reg_decode = sps_pkg::SEL_MVW;
          default:                   reg_decode = sps_pkg::SEL_NONE;
        endcase
      end
    end
  endfunction

  sps_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  assign wr_sel   = reg_decode(wr_addr, reg_bank_sel);
  assign rd_sel   = reg_decode(rd_addr, reg_bank_sel);
  assign wr_scr   = wr_addr[3:2];
  assign rd_scr   = rd_addr[3:2];
  assign wr_err   = (wr_sel == sps_pkg::SEL_NONE);
  assign rd_err   = (rd_sel == sps_pkg::SEL_NONE);
  // Only byte lane zero carries register bits
  assign wr_lane0 = wr_en && wr_strb[0];

  // Next pointer values; the page mux sees these so a write lands on the same-cycle access
  always_comb begin
    ptrs_d = ptrs_q;
    if (wr_lane0) begin
      unique case (wr_sel)
        sps_pkg::SEL_CUR: ptrs_d.cur = wr_data[sps_pkg::PAGE_W-1:0];
        sps_pkg::SEL_STK: ptrs_d.stk = wr_data[sps_pkg::PAGE_W-1:0];
        sps_pkg::SEL_IDX: ptrs_d.idx = wr_data[sps_pkg::PAGE_W-1:0];
        sps_pkg::SEL_MVR: ptrs_d.mvr = wr_data[sps_pkg::PAGE_W-1:0];
        sps_pkg::SEL_MVW: ptrs_d.mvw = wr_data[sps_pkg::PAGE_W-1:0];
        default:          ptrs_d     = ptrs_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptrs_q <= '{cur: sps_pkg::RST_PAGE, stk: sps_pkg::RST_PAGE, idx: sps_pkg::RST_PAGE,
                  mvr: sps_pkg::RST_PAGE, mvw: sps_pkg::RST_PAGE};
    end else begin
      ptrs_q <= ptrs_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SCRATCH; g++) begin : g_scratch
      always_comb begin
        scratch_d[g] = scratch_q[g];
        if (wr_lane0 && wr_sel == sps_pkg::SEL_SCR && wr_scr == 2'(g))
          scratch_d[g] = wr_data[sps_pkg::DATA_W-1:0];
      end
      always_ff @(posedge aclk) begin
        if (!aresetn)
          scratch_q[g] <= sps_pkg::RST_SCRATCH;
        else
          scratch_q[g] <= scratch_d[g];
      end
    end
  endgenerate

  // Read mux; bits above each field read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_sel)
      sps_pkg::SEL_CUR:  rd_data[sps_pkg::PAGE_W-1:0] = ptrs_q.cur;
      sps_pkg::SEL_STK:  rd_data[sps_pkg::PAGE_W-1:0] = ptrs_q.stk;
      sps_pkg::SEL_IDX:  rd_data[sps_pkg::PAGE_W-1:0] = ptrs_q.idx;
      sps_pkg::SEL_MVR:  rd_data[sps_pkg::PAGE_W-1:0] = ptrs_q.mvr;
      sps_pkg::SEL_MVW:  rd_data[sps_pkg::PAGE_W-1:0] = ptrs_q.mvw;
      sps_pkg::SEL_SCR:  rd_data[sps_pkg::DATA_W-1:0] = scratch_q[rd_scr];
      sps_pkg::SEL_STAT: begin
        rd_data[sps_pkg::STAT_MODE_LSB +: 2] = mode_q;
        rd_data[sps_pkg::STAT_STEP_LSB +: 2] = mvi_step_q;
        rd_data[sps_pkg::STAT_BUSY_BIT]      = core_busy_q;
      end
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  // A new request is taken when idle or in the last beat of a move
  assign accept = core_req.valid && !core_busy_q;

  always_comb begin
    step_d = sps_pkg::ST_IDLE;
    if (accept) begin
      if (core_req.kind == sps_pkg::ACC_MVI_RD || core_req.kind == sps_pkg::ACC_MVI_WR)
        step_d = sps_pkg::ST_PTR_RD;
    end else begin
      unique case (mvi_step_q)
        sps_pkg::ST_PTR_RD: step_d = sps_pkg::ST_PTR_WR;
        sps_pkg::ST_PTR_WR: step_d = sps_pkg::ST_DATA;
        sps_pkg::ST_DATA:   step_d = sps_pkg::ST_IDLE;
        sps_pkg::ST_IDLE:   step_d = sps_pkg::ST_IDLE;
      endcase
    end
  end

  // Beat selection: a fresh request or the next step of a running move
  always_comb begin
    beat     = accept || step_d != sps_pkg::ST_IDLE;
    sel_kind = accept ? core_req.kind : sram_kind_q;
    sel_mode = accept ? core_req.page_mode_bits : mode_q;
    sel_data = (step_d == sps_pkg::ST_DATA);
    sel_we   = 1'b0;
    unique case (step_d)
      sps_pkg::ST_IDLE:   sel_we = core_req.we;
      sps_pkg::ST_PTR_RD: sel_we = 1'b0;
      sps_pkg::ST_PTR_WR: sel_we = 1'b1;
      sps_pkg::ST_DATA:   sel_we = (sram_kind_q == sps_pkg::ACC_MVI_WR);
    endcase
  end

  sps_page_sel u_page_sel (
    .ptrs           (ptrs_d),
    .page_mode_bits (sel_mode),
    .kind           (sel_kind),
    .data_phase     (sel_data),
    .page           (sel_page)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mvi_step_q  <= sps_pkg::ST_IDLE;
      core_busy_q <= 1'b0;
    end else begin
      mvi_step_q  <= step_d;
      // Busy drops in the data beat so the core can overlap its next request
      core_busy_q <= (step_d == sps_pkg::ST_PTR_RD) || (step_d == sps_pkg::ST_PTR_WR);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sram_valid_q <= 1'b0;
      sram_page_q  <= sps_pkg::RST_PAGE;
      sram_we_q    <= 1'b0;
      sram_kind_q  <= sps_pkg::ACC_NORMAL;
      mode_q       <= sps_pkg::MODE_ALL_ZERO;
    end else begin
      sram_valid_q <= beat;
      if (beat) begin
        sram_page_q <= sel_page;
        sram_we_q   <= sel_we;
        sram_kind_q <= sel_kind;
        mode_q      <= sel_mode;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  normal_page_a: assert property (sram_valid_q && sram_kind_q == sps_pkg::ACC_NORMAL |->
    sram_page_q == (mode_q[1] ? ptrs_q.cur : sps_pkg::RST_PAGE))
    else $error("normal access on wrong page");
  stack_page_a: assert property (sram_valid_q && sram_kind_q == sps_pkg::ACC_STACK |->
    sram_page_q == ptrs_q.stk)
    else $error("stack access off stack page");
  index_mode_a: assert property (sram_valid_q &&
    (sram_kind_q == sps_pkg::ACC_SRC_IDX || sram_kind_q == sps_pkg::ACC_DST_IDX) |->
    sram_page_q == (mode_q == 2'h2 ? ptrs_q.idx : (mode_q == 2'h0 ? 3'h0 : ptrs_q.stk)))
    else $error("indexed access on wrong page");
  mvi_order_a: assert property (core_req.valid && !core_busy_q &&
    core_req.kind == sps_pkg::ACC_MVI_RD |=>
    mvi_step_q == sps_pkg::ST_PTR_RD && !sram_we_q ##1
    mvi_step_q == sps_pkg::ST_PTR_WR && sram_we_q ##1
    mvi_step_q == sps_pkg::ST_DATA && !sram_we_q && sram_page_q == ptrs_q.mvr)
    else $error("move sequence out of order");
  mvi_ptr_page_a: assert property (sram_valid_q && mvi_step_q == sps_pkg::ST_PTR_WR |->
    sram_page_q == $past(sram_page_q))
    else $error("pointer write page differs from pointer read");
  mvw_page_a: assert property (sram_valid_q && mvi_step_q == sps_pkg::ST_DATA &&
    sram_kind_q == sps_pkg::ACC_MVI_WR |-> sram_page_q == ptrs_q.mvw && sram_we_q)
    else $error("move write data off move-write page");
  stack_fwd_a: assert property (wr_lane0 && wr_sel == sps_pkg::SEL_STK && accept &&
    core_req.kind == sps_pkg::ACC_STACK |=> sram_page_q == $past(wr_data[2:0]))
    else $error("stack access missed the new page");
  stack_reset_a: assert property ($rose(aresetn) |-> ptrs_q.stk == 3'h0 && mode_q == 2'h0)
    else $error("stack page not zero after reset");
  scratch_keep_a: assert property (rd_en && rd_sel == sps_pkg::SEL_SCR |=>
    s_axi_rdata == {24'h000000, $past(scratch_q[rd_scr])} && s_axi_rresp == 2'h0)
    else $error("scratch read returned wrong data");
  bank_gate_a: assert property (rd_en && reg_bank_sel && rd_addr[9:2] == 8'hD1 |=>
    s_axi_rresp == 2'h2)
    else $error("paging register visible outside bank zero");
  upper_zero_a: assert property (rd_en && rd_sel inside {sps_pkg::SEL_CUR, sps_pkg::SEL_MVW} |=>
    s_axi_rdata[31:3] == '0)
    else $error("pointer upper bits not zero");
  ptr_read_page_a: assert property (sram_valid_q && mvi_step_q == sps_pkg::ST_PTR_RD |->
    sram_page_q == (mode_q[1] ? ptrs_q.cur : sps_pkg::RST_PAGE))
    else $error("move pointer read off normal page");
  mvr_page_a: assert property (sram_valid_q && mvi_step_q == sps_pkg::ST_DATA &&
    sram_kind_q == sps_pkg::ACC_MVI_RD |-> sram_page_q == ptrs_q.mvr && !sram_we_q)
    else $error("move read data off move-read page");
  // A refused write must not leak into the pointer
  bank_write_a: assert property (wr_en && reg_bank_sel && wr_addr[9:2] == sps_pkg::IDX_STACK_PAGE |=>
    $stable(ptrs_q.stk) && s_axi_bresp == sps_pkg::RESP_SLVERR)
    else $error("paging register written outside bank zero");

  mvi_write_c: cover property (mvi_step_q == sps_pkg::ST_DATA && sram_kind_q == sps_pkg::ACC_MVI_WR);
  idx_stack_c: cover property (sram_valid_q && sram_kind_q == sps_pkg::ACC_SRC_IDX && mode_q == 2'h3);
  stack_fwd_c: cover property (wr_lane0 && wr_sel == sps_pkg::SEL_STK && accept);
  mvi_read_c: cover property (mvi_step_q == sps_pkg::ST_DATA && sram_kind_q == sps_pkg::ACC_MVI_RD);
  bank_scr_c: cover property (rd_en && reg_bank_sel && rd_sel == sps_pkg::SEL_SCR);
endmodule // sps_page_ctrl

/* File: verif/sps_core_model.sv */
`timescale 1ns/1ps
module sps_core_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench command
  input  wire logic        issue,
  input  sps_pkg::sps_acc_t kind,
  input  wire logic        we,
  input  wire logic [1:0]  mode,
  // Core request
  input  wire logic        core_busy_q,
  output sps_pkg::sps_req_t core_req
);
  // Idle fields toggle every cycle so a stale request is never mistaken for a fresh one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_req <= '0;
    end else begin
      core_req.valid          <= issue && !core_busy_q;
      core_req.kind           <= issue ? kind : sps_pkg::sps_acc_t'(~core_req.kind);
      core_req.we             <= issue ? we : !core_req.we;
      core_req.page_mode_bits <= issue ? mode : ~core_req.page_mode_bits;
    end
  end
endmodule // sps_core_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module testbench;
  logic aclk = 0, aresetn = 0, reg_bank_sel = 0, issue = 0, we = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode = 0;
  logic core_busy_q, sram_valid_q, sram_we_q;
  logic [2:0] sram_page_q, p[5];
  sps_pkg::sps_acc_t sram_kind_q, kind = sps_pkg::ACC_NORMAL;
  sps_pkg::sps_step_t mvi_step_q;
  sps_pkg::sps_req_t core_req;
  int miscompares = 0, samples_checked = 0;
  logic [7:0] ri[5] = '{sps_pkg::IDX_CURRENT_PAGE, sps_pkg::IDX_STACK_PAGE, sps_pkg::IDX_INDEX_PAGE,
                        sps_pkg::IDX_MOVE_READ, sps_pkg::IDX_MOVE_WRITE};
  sps_page_ctrl dut_u (.*);
  sps_core_model core_u (.aclk(aclk), .aresetn(aresetn), .issue(issue), .kind(kind), .we(we), .mode(mode),
                         .core_busy_q(core_busy_q), .core_req(core_req));
  always #5 aclk = ~aclk;
  function automatic logic [11:0] ba(logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  function automatic logic [2:0] exp_page(sps_pkg::sps_acc_t k, logic [1:0] m, logic dat);
    logic [2:0] np;
    np = m[1] ? p[0] : 3'h0;
    case (k)
      sps_pkg::ACC_STACK: return p[1];
      sps_pkg::ACC_SRC_IDX, sps_pkg::ACC_DST_IDX: return m == 2'h0 ? 3'h0 : (m == 2'h2 ? p[2] : p[1]);
      sps_pkg::ACC_MVI_RD: return dat ? p[3] : np;
      sps_pkg::ACC_MVI_WR: return dat ? p[4] : np;
      default: return np;
    endcase
  endfunction
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready && !ta) begin
        ta = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready && !tw) begin
        tw = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed, s_axi_rdata)
  endtask
  task automatic acc(input sps_pkg::sps_acc_t k, input logic [1:0] m, input logic w);
    bit mv;
    mv = k inside {sps_pkg::ACC_MVI_RD, sps_pkg::ACC_MVI_WR};
    @(posedge aclk);
    issue <= 1;
    kind <= k;
    mode <= m;
    we <= w;
    @(posedge aclk);
    issue <= 0;
    for (int j = 0; j < (mv ? 3 : 1); j++) begin
      @(posedge aclk);
      #1;
      `CHK("valid", 1'b1, sram_valid_q)
      `CHK("page", exp_page(k, m, !mv || j == 2), sram_page_q)
      `CHK("kind", k, sram_kind_q)
      `CHK("we", mv ? (j == 1 || (j == 2 && k == sps_pkg::ACC_MVI_WR)) : w, sram_we_q)
      if (mv) `CHK("step", j == 0 ? sps_pkg::ST_PTR_RD : j == 1 ? sps_pkg::ST_PTR_WR : sps_pkg::ST_DATA, mvi_step_q)
      `CHK("busy", mv && j < 2, core_busy_q)
    end
  endtask
  task automatic rst_check;
    p = '{default: 3'h0};
    for (int i = 0; i < 5; i++) axr(ba(ri[i]), 32'h0, sps_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) axr(ba(sps_pkg::IDX_SCRATCH_BASE + i[7:0]), 32'h0, sps_pkg::RESP_OKAY);
  endtask
  task automatic test_done;
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(32'h23d0332d));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rst_check;
    acc(sps_pkg::ACC_STACK, 2'h3, 1'b1);
    $display("Reset test done");
    repeat (10) begin
      for (int i = 0; i < 5; i++) begin
        p[i] = 3'($urandom);
        axw(ba(ri[i]), {29'h0, p[i]}, sps_pkg::RESP_OKAY);
        axr(ba(ri[i]), {29'h0, p[i]}, sps_pkg::RESP_OKAY);
      end
      for (int m = 0; m < 4; m++)
        for (int k = 0; k < 6; k++) acc(sps_pkg::sps_acc_t'(k), m[1:0], 1'($urandom));
    end
    // Stack accesses run on every cycle while the pointer write lands
    issue <= 1;
    kind <= sps_pkg::ACC_STACK;
    p[1] = 3'($urandom);
    axw(ba(sps_pkg::IDX_STACK_PAGE), {29'h0, p[1]}, sps_pkg::RESP_OKAY);
    issue <= 0;
    acc(sps_pkg::ACC_STACK, 2'h1, 1'b0);
    axr(ba(sps_pkg::IDX_STATUS), 32'h1, sps_pkg::RESP_OKAY);
    $display("Paging test done");
    reg_bank_sel <= 1;
    axw(ba(sps_pkg::IDX_STACK_PAGE), 32'h5, sps_pkg::RESP_SLVERR);
    axr(ba(sps_pkg::IDX_STACK_PAGE), 32'h0, sps_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      logic [7:0] v;
      v = 8'($urandom);
      axw(ba(sps_pkg::IDX_SCRATCH_BASE + i[7:0]), {24'h0, v}, sps_pkg::RESP_OKAY);
      axr(ba(sps_pkg::IDX_SCRATCH_BASE + i[7:0]), {24'h0, v}, sps_pkg::RESP_OKAY);
    end
    axr(12'hFFC, 32'h0, sps_pkg::RESP_SLVERR);
    reg_bank_sel <= 0;
    axr(ba(sps_pkg::IDX_STACK_PAGE), {29'h0, p[1]}, sps_pkg::RESP_OKAY);
    $display("Bank test done");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rst_check;
    $display("Second reset test done");
    test_done;
  end
endmodule // testbench
